//--- rtl/dpbs_defs.vh
// Constants for the dual-port buffer block sequencer: register map, fields, resets.
// Assumes a single 40 MHz clock and an AXI4-Lite master for the local processor.
//
// Summary of operation
// [R1] A software reset clears the direction bit (host-to-peripheral), buffer size and addressing mode.
// [R2] In extended mode software clears both high pointer registers before a block write.
// [R3] For a host-to-peripheral block software loads the stop pointer with the block length first.
// [R4] Setting the host write start latch starts DMA request/acknowledge cycles into the buffer.
// [R5] In a host-to-buffer transfer the complete flag sets when the write pointer equals the stop pointer.
// [R6] Software tells the peripheral to start only after the complete flag is set in a single write.
// [R7] The read pointer advances on every peripheral buffer access; here only in direction 0, the write pointer in direction 1.
// [R8] A next peripheral block may fill the buffer while host DMA of the previous one runs, given room.
// [R9] Software watches the read pointer or counts blocks to avoid peripheral overruns.
// [R10] Software may rewrite the stop pointer and restart DMA only with enough data buffered.
// [R11] A multi-block write starts with one host block; then both sides may run together.
// [R12] In a buffer-to-host transfer the complete flag sets when the read pointer equals the stop pointer.
// [R13] The write pointer always holds the location after the last entry written.
// [R14] The complete flag stays set until a latch bit is set or a reset is issued.
`ifndef DPBS_DEFS_VH
`define DPBS_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define DPBS_OFF_CTRL      12'h000
`define DPBS_OFF_STATUS    12'h004
`define DPBS_OFF_STOP      12'h008
`define DPBS_OFF_WPTR      12'h00C
`define DPBS_OFF_RPTR      12'h010
`define DPBS_OFF_PTRHI     12'h014
`define DPBS_OFF_IRQ_STAT  12'h018
`define DPBS_OFF_IRQ_MASK  12'h01C

// ****************************************
// Control fields
// ****************************************
`define DPBS_CTRL_RESET    0
`define DPBS_CTRL_DIR      1
`define DPBS_CTRL_WLATCH   2
`define DPBS_CTRL_RLATCH   3
`define DPBS_CTRL_EXT      4
`define DPBS_CTRL_SIZE_LO  5
`define DPBS_CTRL_SIZE_HI  6

// Status / interrupt fields
`define DPBS_ST_DONE       0
`define DPBS_ST_ACTIVE     1
`define DPBS_IRQ_DONE      0
`define DPBS_IRQ_WRAP      1

// ****************************************
// Widths and reset values
// ****************************************
`define DPBS_PTR_W         14
`define DPBS_PTR_RST       14'h0000
`define DPBS_SIZE_RST      2'h0
`define DPBS_HI_RST        8'h00

`endif

//--- rtl/dpbs_seq.v
// Block-transfer sequencer of a dual-port buffer controller, with an AXI4-Lite
// register slave, host DMA request/acknowledge port and peripheral access port.
// Assumes all inputs are synchronous to aclk; buffer RAM itself lies outside.
`timescale 1ns/1ps
`include "dpbs_defs.vh"

module dpbs_seq (
	// Clock, reset, enable
	input  wire                   aclk,
	input  wire                   aresetn,
	input  wire                   clk_en,
	// AXI4-Lite write address
	input  wire [11:0]            s_axi_awaddr,
	input  wire                   s_axi_awvalid,
	output wire                   s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0]            s_axi_wdata,
	input  wire [3:0]             s_axi_wstrb,
	input  wire                   s_axi_wvalid,
	output wire                   s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]             s_axi_bresp,
	output reg                    s_axi_bvalid,
	input  wire                   s_axi_bready,
	// AXI4-Lite read address
	input  wire [11:0]            s_axi_araddr,
	input  wire                   s_axi_arvalid,
	output wire                   s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0]            s_axi_rdata,
	output reg  [1:0]             s_axi_rresp,
	output reg                    s_axi_rvalid,
	input  wire                   s_axi_rready,
	// Host DMA
	output wire                   dma_req,
	input  wire                   dma_ack,
	// Peripheral buffer access
	input  wire                   periph_strobe,
	// Buffer addresses
	output reg  [`DPBS_PTR_W-1:0] host_addr,
	output reg  [`DPBS_PTR_W-1:0] periph_addr,
	// Interrupt
	output wire                   irq
);

	// ****************************************
	// Registers
	// ****************************************
	// Control and transfer state
	reg                   dir_r;
	reg                   ext_r;
	reg [1:0]             size_r;
	reg                   active_r;
	reg                   done_r;
	reg [`DPBS_PTR_W-1:0] stop_r;
	reg [`DPBS_PTR_W-1:0] wptr_r;
	reg [`DPBS_PTR_W-1:0] rptr_r;
	reg [7:0]             rhi_r;
	reg [7:0]             whi_r;
	reg [1:0]             irq_stat_r;
	reg [1:0]             irq_mask_r;
	// Write channel holding registers
	reg                   aw_got_r;
	reg                   w_got_r;
	reg [11:0]            awaddr_r;
	reg [31:0]            wdata_r;
	reg [3:0]             wstrb_r;

	// ****************************************
	// AXI4-Lite handshakes
	// ****************************************
	// Readies drop with clk_en so no transfer is taken while state is frozen;
	// a master that keeps valid up simply waits for the enable to return
	wire aw_fire = s_axi_awvalid & s_axi_awready;
	wire w_fire  = s_axi_wvalid & s_axi_wready;
	assign s_axi_awready = clk_en & ~aw_got_r & ~s_axi_bvalid;
	assign s_axi_wready  = clk_en & ~w_got_r & ~s_axi_bvalid;
	assign s_axi_arready = clk_en & ~s_axi_rvalid;

	wire        aw_have = aw_got_r | aw_fire;
	wire        w_have  = w_got_r | w_fire;
	wire        wr_go   = clk_en & aw_have & w_have & ~s_axi_bvalid;
	wire [11:0] wa      = aw_got_r ? awaddr_r : s_axi_awaddr;
	wire [31:0] wd      = w_got_r ? wdata_r : s_axi_wdata;
	wire [3:0]  ws      = w_got_r ? wstrb_r : s_axi_wstrb;
	// A write with both low strobes clear is answered OKAY at a mapped offset but changes nothing
	wire        wr_ok   = wr_go & (ws[0] | ws[1]);

	// Decoded write strobes; only the low half-word carries register bits
	wire wr_ctrl  = wr_ok & (wa == `DPBS_OFF_CTRL);
	wire wr_stop  = wr_ok & (wa == `DPBS_OFF_STOP);
	wire wr_hi    = wr_ok & (wa == `DPBS_OFF_PTRHI);
	wire wr_istat = wr_ok & (wa == `DPBS_OFF_IRQ_STAT);
	wire wr_imask = wr_ok & (wa == `DPBS_OFF_IRQ_MASK);
	wire mapped_w = (wa == `DPBS_OFF_CTRL) | (wa == `DPBS_OFF_STATUS) |
			(wa == `DPBS_OFF_STOP) | (wa == `DPBS_OFF_WPTR) |
			(wa == `DPBS_OFF_RPTR) | (wa == `DPBS_OFF_PTRHI) |
			(wa == `DPBS_OFF_IRQ_STAT) | (wa == `DPBS_OFF_IRQ_MASK);

	wire soft_rst = wr_ctrl & wd[`DPBS_CTRL_RESET];
	wire wlatch   = wr_ctrl & wd[`DPBS_CTRL_WLATCH] & ~soft_rst;
	wire rlatch   = wr_ctrl & wd[`DPBS_CTRL_RLATCH] & ~soft_rst;

	// ****************************************
	// Transfer engine
	// ****************************************
	// Direction 0 moves host data into the buffer, 1 moves buffer data to the host
	wire host_beat = active_r & dma_ack & clk_en;
	// Peripheral beats are taken in every state, so a next block can fill the
	// buffer while host DMA of the earlier one runs; room is software's concern
	wire per_beat  = periph_strobe & clk_en;                           // [R8]
	wire [`DPBS_PTR_W-1:0] wptr_nxt = wptr_r + 14'h0001;
	wire [`DPBS_PTR_W-1:0] rptr_nxt = rptr_r + 14'h0001;

	// Host moves the write pointer when filling, the read pointer when draining
	wire host_w = host_beat & ~dir_r;
	wire host_r = host_beat & dir_r;
	// Peripheral uses the opposite pointer of the host
	wire per_w  = per_beat & dir_r;
	wire per_r  = per_beat & ~dir_r;
	// Pointers wrap at the buffer depth; no full or empty tracking is kept here
	wire inc_w  = host_w | per_w;
	wire inc_r  = host_r | per_r;

	// Completion is checked on the advanced pointer so the flag rises with the last beat
	wire hit = (host_w & (wptr_nxt == stop_r)) |                       // [R5]
		   (host_r & (rptr_nxt == stop_r));                        // [R12]

	// Request falls with the completing beat; a host that acks once more after
	// that is ignored, because active is already low
	assign dma_req = active_r & ~done_r;

	always @(posedge aclk) begin
		if (!aresetn) begin
			dir_r    <= 1'b0;
			ext_r    <= 1'b0;
			size_r   <= `DPBS_SIZE_RST;
			active_r <= 1'b0;
			done_r   <= 1'b0;
			stop_r   <= `DPBS_PTR_RST;
			wptr_r   <= `DPBS_PTR_RST;
			rptr_r   <= `DPBS_PTR_RST;
			rhi_r    <= `DPBS_HI_RST;
			whi_r    <= `DPBS_HI_RST;
		end else if (clk_en) begin
			// Stop pointer, high latches and interrupt state survive a soft reset
			if (soft_rst) begin
				dir_r    <= 1'b0;                             // [R1]
				ext_r    <= 1'b0;                             // [R1]
				size_r   <= `DPBS_SIZE_RST;                   // [R1]
				active_r <= 1'b0;
				done_r   <= 1'b0;                             // [R14]
				wptr_r   <= `DPBS_PTR_RST;
				rptr_r   <= `DPBS_PTR_RST;
			end else begin
				if (wr_ctrl) begin
					dir_r  <= wd[`DPBS_CTRL_DIR];
					ext_r  <= wd[`DPBS_CTRL_EXT];
					size_r <= wd[`DPBS_CTRL_SIZE_HI:`DPBS_CTRL_SIZE_LO];
				end
				// A latch write in the cycle of the final beat restarts the engine
				if (wlatch | rlatch) begin
					active_r <= 1'b1;                     // [R4]
					done_r   <= 1'b0;                     // [R14]
				end else if (hit) begin
					active_r <= 1'b0;
					done_r   <= 1'b1;                     // [R5] [R12]
				end
				if (inc_w)
					wptr_r <= wptr_nxt;                   // [R13]
				if (inc_r)
					rptr_r <= rptr_nxt;                   // [R7]
			end
			if (wr_stop)
				stop_r <= wd[`DPBS_PTR_W-1:0];
			if (wr_hi) begin
				// External latches are not cleared by a soft reset; software loads them
				rhi_r <= wd[7:0];
				whi_r <= wd[15:8];
			end
		end
	end

	// Address outputs registered from the pointers feeding each port
	// The cycle of lag keeps them glitch-free; the far side must allow for it
	always @(posedge aclk) begin
		if (!aresetn) begin
			host_addr   <= `DPBS_PTR_RST;
			periph_addr <= `DPBS_PTR_RST;
		end else if (clk_en) begin
			host_addr   <= dir_r ? rptr_r : wptr_r;
			periph_addr <= dir_r ? wptr_r : rptr_r;
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	// Wrap of a pointer warns extended-mode software to reload the high latch
	wire wrap_ev = (inc_w & (wptr_nxt == `DPBS_PTR_RST)) |
		       (inc_r & (rptr_nxt == `DPBS_PTR_RST));
	wire [1:0] ev = {wrap_ev & ext_r, hit & ~(wlatch | rlatch) & ~soft_rst};

	// Set wins over a write-one-to-clear in the same cycle
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_r <= 2'h0;
			irq_mask_r <= 2'h0;
		end else if (clk_en) begin
			irq_stat_r <= (irq_stat_r & ~({2{wr_istat}} & wd[1:0])) | ev;
			if (wr_imask)
				irq_mask_r <= wd[1:0];
		end
	end
	// Level output built from registers only, so it cannot glitch
	assign irq = |(irq_stat_r & irq_mask_r);

	// ****************************************
	// AXI4-Lite write channel
	// ****************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r     <= 1'b0;
			w_got_r      <= 1'b0;
			awaddr_r     <= 12'h000;
			wdata_r      <= 32'h00000000;
			wstrb_r      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else if (clk_en) begin
			// Address and data may come in either order; each is held
			// here until its partner arrives
			if (aw_fire) begin
				awaddr_r <= s_axi_awaddr;
				aw_got_r <= 1'b1;
			end
			if (w_fire) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
				w_got_r <= 1'b1;
			end
			if (wr_go) begin
				aw_got_r     <= 1'b0;
				w_got_r      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped_w ? 2'h0 : 2'h2;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	// Decode is combinational on the address; the result is captured with the
	// handshake, so read data stays stable while rvalid stands
	reg [31:0] rd_mux;
	reg        rd_ok;
	always @* begin
		rd_mux = 32'h00000000;
		rd_ok  = 1'b1;
		if (s_axi_araddr == `DPBS_OFF_CTRL)
			rd_mux = {25'h0000000, size_r, ext_r, 2'h0, dir_r, 1'b0};
		else if (s_axi_araddr == `DPBS_OFF_STATUS)
			rd_mux = {30'h00000000, active_r, done_r};
		else if (s_axi_araddr == `DPBS_OFF_STOP)
			rd_mux = {18'h00000, stop_r};
		else if (s_axi_araddr == `DPBS_OFF_WPTR)
			rd_mux = {18'h00000, wptr_r};
		else if (s_axi_araddr == `DPBS_OFF_RPTR)
			rd_mux = {18'h00000, rptr_r};
		else if (s_axi_araddr == `DPBS_OFF_PTRHI)
			rd_mux = {16'h0000, whi_r, rhi_r};
		else if (s_axi_araddr == `DPBS_OFF_IRQ_STAT)
			rd_mux = {30'h00000000, irq_stat_r};
		else if (s_axi_araddr == `DPBS_OFF_IRQ_MASK)
			rd_mux = {30'h00000000, irq_mask_r};
		else
			rd_ok = 1'b0;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= 2'h0;
		end else if (clk_en) begin
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

//--- tb/dpbs_seq_checker.sv
// Checker for the block sequencer: bus handshakes, DMA start and stop, pointer steps.
// Bound to dpbs_seq from the bench top; sees only the design's ports.
`timescale 1ns/1ps
`include "dpbs_defs.vh"
module dpbs_seq_checker (
	input wire                   aclk, aresetn, s_axi_awready, s_axi_bvalid, s_axi_bready,
	input wire                   s_axi_arready, s_axi_rvalid, s_axi_rready, irq,
	input wire                   dma_req, dma_ack, periph_strobe,
	input wire [`DPBS_PTR_W-1:0] host_addr, periph_addr
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Isolated accesses only: address outputs lag the pointers by a cycle
	sequence s_beat; !dma_ack ##1 (dma_req && dma_ack) ##1 !dma_ack; endsequence
	sequence s_strobe; !periph_strobe ##1 periph_strobe ##1 !periph_strobe; endsequence
	property p_rst; $rose(aresetn) |-> !dma_req && !irq && !s_axi_bvalid && !s_axi_rvalid;
	endproperty
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
	property p_noaw; s_axi_bvalid |-> !s_axi_awready && !(s_axi_rvalid && s_axi_arready); endproperty
	property p_start; $rose(dma_req) |-> $rose(s_axi_bvalid); endproperty
	property p_stop; $fell(dma_req) |-> $past(dma_ack) || $rose(s_axi_bvalid); endproperty
	property p_hstep; s_beat |=> host_addr == $past(host_addr, 2) + 1'b1; endproperty
	property p_pstep; s_strobe |=> periph_addr == $past(periph_addr, 2) + 1'b1; endproperty
	a_rst: assert property (p_rst) else $error("outputs not clear after reset");
	a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
	a_bdone: assert property (p_bdone) else $error("bvalid stuck");
	a_rhold: assert property (p_rhold) else $error("rvalid dropped early");
	a_noaw: assert property (p_noaw) else $error("ready while response pending");
	a_start: assert property (p_start) else $error("request without latch write");
	a_stop: assert property (p_stop) else $error("request fell without a beat");
	a_hstep: assert property (p_hstep) else $error("host pointer step wrong");
	a_pstep: assert property (p_pstep) else $error("peripheral pointer step wrong");
endmodule

//--- tb/dpbs_far_model.sv
// Host DMA channel and peripheral controller beside the sequencer.
// Assumes aclk and aresetn of the design; slow makes the host ack every other cycle.
`timescale 1ns/1ps
module dpbs_far_model (
	input  wire aclk, aresetn, dma_req, slow, periph_go,
	output reg  dma_ack, periph_strobe
);
	always @(posedge aclk) begin
		if (!aresetn) begin
			dma_ack <= 1'b0;
			periph_strobe <= 1'b0;
		end else begin
			dma_ack <= dma_req && !(slow && dma_ack);
			periph_strobe <= periph_go && !periph_strobe;
		end
	end
endmodule

//--- tb/dpbs_seq_test.sv
// Self-checking bench of the block sequencer over AXI4-Lite with far-side model.
// Assumes the checker and model files are compiled first.
`timescale 1ns/1ps
`include "dpbs_defs.vh"
module dpbs_seq_test;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic slow = 0, pgo = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rv;
	logic [1:0] rr;
	wire awready, wready, bvalid, arready, rvalid, dma_req, dma_ack, pstb, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [`DPBS_PTR_W-1:0] haddr, paddr;
	int n_errors = 0, check_count = 0;
	dpbs_seq uut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dma_req(dma_req),
		.dma_ack(dma_ack), .periph_strobe(pstb), .host_addr(haddr), .periph_addr(paddr),
		.irq(irq));
	dpbs_far_model far (.aclk(aclk), .aresetn(aresetn), .dma_req(dma_req), .slow(slow),
		.periph_go(pgo), .dma_ack(dma_ack), .periph_strobe(pstb));
	initial forever #12.5 aclk = ~aclk;
	task results;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h", $time, m, got);
		end
	endtask
	task tmo;
		n_errors++;
		$display("wrong value at %0t: timeout", $time);
		results;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge aclk);
		awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid === 1'b1) break;
		end
		bready <= 0; rr = bresp;
		if (i == 50) tmo;
	endtask
	task rd(input logic [11:0] a);
		int i;
		@(posedge aclk);
		araddr <= a; arvalid <= 1; rready <= 1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
			if (rvalid === 1'b1) break;
		end
		rready <= 0; rv = rdata; rr = rresp;
		if (i == 50) tmo;
	endtask
	task wait_done;
		int i;
		for (i = 0; i < 300 && dma_req !== 1'b0; i++) @(posedge aclk);
		if (i == 300) tmo;
	endtask
	task t_reset;
		rd(`DPBS_OFF_CTRL); chk(rv, 0, "ctrl");
		rd(`DPBS_OFF_STATUS); chk(rv, 0, "status");
		$display("t_reset done");
	endtask
	task t_write_block;
		wr(`DPBS_OFF_CTRL, 32'h1);
		wr(`DPBS_OFF_PTRHI, 32'h0);
		wr(`DPBS_OFF_STOP, 32'h4);
		wr(`DPBS_OFF_IRQ_MASK, 32'h1);
		wr(`DPBS_OFF_CTRL, 32'h4); chk(dma_req, 1, "req");
		wait_done;
		rd(`DPBS_OFF_WPTR); chk(rv, 4, "wptr");
		repeat (20) @(posedge aclk);
		rd(`DPBS_OFF_STATUS); chk(rv[0], 1, "done held");
		chk(irq, 1, "irq");
		wr(`DPBS_OFF_IRQ_MASK, 32'h0); chk(irq, 0, "irq masked");
		wr(`DPBS_OFF_IRQ_MASK, 32'h1); chk(irq, 1, "irq unmasked");
		wr(`DPBS_OFF_IRQ_STAT, 32'h1); chk(irq, 0, "irq cleared");
		$display("t_write_block done");
	endtask
	task t_periph;
		pgo <= 1; repeat (6) @(posedge aclk); pgo <= 0;
		repeat (2) @(posedge aclk);
		rd(`DPBS_OFF_RPTR); chk(rv, 3, "rptr");
		$display("t_periph done");
	endtask
	task t_read_block;
		wr(`DPBS_OFF_CTRL, 32'h1); wr(`DPBS_OFF_CTRL, 32'h2);
		pgo <= 1; repeat (8) @(posedge aclk); pgo <= 0;
		repeat (2) @(posedge aclk);
		rd(`DPBS_OFF_WPTR); chk(rv, 4, "wptr read dir");
		wr(`DPBS_OFF_STOP, 32'h2); slow <= 1;
		wr(`DPBS_OFF_CTRL, 32'hA); pgo <= 1;
		wait_done; pgo <= 0;
		rd(`DPBS_OFF_RPTR); chk(rv, 2, "rptr");
		wr(`DPBS_OFF_STOP, 32'h4); wr(`DPBS_OFF_CTRL, 32'hA);
		wait_done;
		rd(`DPBS_OFF_RPTR); chk(rv, 4, "rptr second");
		rd(`DPBS_OFF_STATUS); chk(rv[0], 1, "done read");
		wr(`DPBS_OFF_CTRL, 32'h1); rd(`DPBS_OFF_CTRL); chk(rv, 0, "soft reset ctrl");
		rd(`DPBS_OFF_STATUS); chk(rv, 0, "soft reset status");
		$display("t_read_block done");
	endtask
	task t_unmapped;
		rd(12'h800); chk(rr, 2'h2, "rresp");
		wr(12'h800, 32'h5); chk(rr, 2'h2, "bresp");
		$display("t_unmapped done");
	endtask
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		t_reset;
		t_write_block;
		t_periph;
		t_read_block;
		t_unmapped;
		results;
	end
endmodule
bind dpbs_seq dpbs_seq_checker chk_i (.aclk(aclk), .aresetn(aresetn), .irq(irq),
	.s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.dma_req(dma_req), .dma_ack(dma_ack), .periph_strobe(periph_strobe),
	.host_addr(host_addr), .periph_addr(periph_addr));
